// >>> verilog/irq_params.svh
// Addresses, reset values, field positions and timing figures of the interrupt request control
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

`define ADDR_REQ_LO 16'hffe0
`define ADDR_REQ_HI 16'hffe1
`define ADDR_MASK_LO 16'hffe4
`define ADDR_MASK_HI 16'hffe5
`define ADDR_EDGE_SEL 16'hffec

`define RST_REQ 8'h00
`define RST_MASK 8'hff
`define RST_EDGE_SEL 8'h00
`define EDGE_SEL_WMASK 8'h3c
`define HI_USED_MASK 8'h0f
`define RD_ZERO 8'h00

`define NUM_SRC 12
`define SRC_WDT 0
`define SRC_PIN_A 1
`define SRC_PIN_B 2
`define SRC_TI_RISE 3
`define SRC_TI_FALL 4
`define SRC_REMOTE 5
`define SRC_KEY 6
`define SRC_SERIAL 7
`define SRC_TM_A 8
`define SRC_TM_B 9
`define SRC_WATCH 10
`define SRC_WATCH_IV 11

`define ESEL_A_LSB 2
`define ESEL_B_LSB 4
`define ESEL_FALL 2'h0
`define ESEL_RISE 2'h1
`define ESEL_BOTH 2'h3

`define NMI_VECTOR 16'h0004
`define VEC_BASE 16'h0004
`define VEC_STEP 16'h0002

`define LAT_MIN_CLK 9
`define LAT_MAX_CLK 19

`endif

// >>> verilog/irq_pkg.sv
// Types shared by the interrupt request control modules
package irq_pkg;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic bit_wr;
		logic [2:0] bit_pos;
		logic bit_val;
	} bus_req_t;

	typedef struct packed {
		logic wdt_ovf;
		logic remote_ovf;
		logic key_scan;
		logic serial_done;
		logic timer_a_match;
		logic timer_b_match;
		logic watch;
		logic watch_interval;
	} src_evt_t;

	typedef struct packed {
		logic prev;
		logic primed;
	} edge_state_t;

	typedef struct packed {
		logic [11:0] req_flags;
		logic [11:0] mask_flags;
		logic [7:0] edge_sel;
		logic nmi_pending;
		logic [7:0] rdata;
		logic nmi_out;
		logic irq_out;
		logic [15:0] vector;
		logic [3:0] vec_idx;
		logic standby;
		logic ie_clear;
	} ctl_state_t;

endpackage

// >>> verilog/pin_edge_detect.sv
// Rising and falling edge detector for one synchronous pin
`timescale 1ns/1ps
module pin_edge_detect (
	input wire logic clk,
	input wire logic nrst,
	input wire logic level,
	output logic rise,
	output logic fall
);
	irq_pkg::edge_state_t st_r;
	irq_pkg::edge_state_t st_nxt;

	always_comb begin
		st_nxt.prev = level;
		st_nxt.primed = 1'b1;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// No edge before the first sample after reset, so a high pin does not fire
	assign rise = st_r.primed & level & ~st_r.prev;
	assign fall = st_r.primed & ~level & st_r.prev;
endmodule // pin_edge_detect

// >>> verilog/fixed_priority_pick.sv
// Fixed priority selector: lowest set index wins
`timescale 1ns/1ps
module fixed_priority_pick (
	input wire logic [11:0] eligible,
	output logic valid,
	output logic [3:0] index
);
	always_comb begin
		valid = 1'b0;
		index = 4'h0;
		for (int i = 11; i >= 0; i--) begin
			if (eligible[i]) begin
				valid = 1'b1;
				index = 4'(i);
			end
		end
	end
endmodule // fixed_priority_pick

// >>> verilog/interrupt_request_control.sv
// Interrupt request control: request and mask flags, edge select, priority and vector
`timescale 1ns/1ps
`include "irq_params.svh"
module interrupt_request_control (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire irq_pkg::bus_req_t BUS_REQ,
	output logic [7:0] RDATA,
	input wire irq_pkg::src_evt_t SRC_EVENTS,
	input wire logic PIN_A,
	input wire logic PIN_B,
	input wire logic TIMER_PIN,
	input wire logic WDT_INTERVAL_MODE,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic ACK,
	output logic NMI_REQ,
	output logic IRQ_REQ,
	output logic [15:0] VECTOR,
	output logic STANDBY_RELEASE,
	output logic IE_CLEAR
);
	irq_pkg::ctl_state_t st_r;
	irq_pkg::ctl_state_t st_nxt;

	logic pin_a_rise;
	logic pin_a_fall;
	logic pin_b_rise;
	logic pin_b_fall;
	logic ti_rise;
	logic ti_fall;
	logic pick_valid;
	logic [3:0] pick_idx;
	logic [11:0] eligible;

	// Byte write or single-bit write onto an 8-bit register image
	function automatic logic [7:0] apply_write(input logic [7:0] old, input irq_pkg::bus_req_t req);
		logic [7:0] res;
		res = old;
		if (req.wr) begin
			res = req.wdata;
		end else if (req.bit_wr) begin
			res[req.bit_pos] = req.bit_val;
		end
		return res;
	endfunction

	function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
		logic hit;
		hit = 1'b0;
		case (sel)
			`ESEL_FALL: hit = fall;
			`ESEL_RISE: hit = rise;
			`ESEL_BOTH: hit = rise | fall;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	function automatic logic [15:0] vector_of(input logic [3:0] idx);
		return 16'(`VEC_BASE + `VEC_STEP * {12'h000, idx});
	endfunction

	pin_edge_detect u_pin_a (
		.clk(CLK_SYS),
		.nrst(NRST),
		.level(PIN_A),
		.rise(pin_a_rise),
		.fall(pin_a_fall)
	);

	pin_edge_detect u_pin_b (
		.clk(CLK_SYS),
		.nrst(NRST),
		.level(PIN_B),
		.rise(pin_b_rise),
		.fall(pin_b_fall)
	);

	pin_edge_detect u_timer_pin (
		.clk(CLK_SYS),
		.nrst(NRST),
		.level(TIMER_PIN),
		.rise(ti_rise),
		.fall(ti_fall)
	);

	// Arbitration runs on registered flags to keep the bus write off the vector path
	assign eligible = st_r.req_flags & ~st_r.mask_flags;

	fixed_priority_pick u_pick (
		.eligible(eligible),
		.valid(pick_valid),
		.index(pick_idx)
	);

	always_comb begin
		logic [11:0] flags;
		logic [11:0] masks;
		logic [11:0] sets;
		logic [7:0] esel;
		logic [7:0] byte_lo;
		logic [7:0] byte_hi;
		logic nmi;
		logic flag_access;
		logic wr_any;
		logic ack_irq;
		logic ack_nmi;

		byte_lo = 8'h00;
		byte_hi = 8'h00;
		sets = 12'h000;
		flag_access = 1'b0;
		flags = st_r.req_flags;
		masks = st_r.mask_flags;
		esel = st_r.edge_sel;
		nmi = st_r.nmi_pending;
		wr_any = BUS_REQ.wr | BUS_REQ.bit_wr;
		ack_nmi = ACK & st_r.nmi_out;
		ack_irq = ACK & st_r.irq_out & ~st_r.nmi_out;

		// Software writes: byte or single bit; the edge select takes byte writes only
		if (wr_any && BUS_REQ.addr == `ADDR_REQ_LO) begin
			byte_lo = apply_write(flags[7:0], BUS_REQ);
			if (!WDT_INTERVAL_MODE) begin
				byte_lo[`SRC_WDT] = flags[`SRC_WDT];
			end
			flags[7:0] = byte_lo;
		end
		if (wr_any && BUS_REQ.addr == `ADDR_REQ_HI) begin
			byte_hi = apply_write({4'h0, flags[11:8]}, BUS_REQ);
			flags[11:8] = byte_hi[3:0];
		end
		if (wr_any && BUS_REQ.addr == `ADDR_MASK_LO) begin
			masks[7:0] = apply_write(masks[7:0], BUS_REQ);
		end
		if (wr_any && BUS_REQ.addr == `ADDR_MASK_HI) begin
			byte_hi = apply_write({4'hf, masks[11:8]}, BUS_REQ);
			masks[11:8] = byte_hi[3:0];
		end
		if (BUS_REQ.wr && BUS_REQ.addr == `ADDR_EDGE_SEL) begin
			esel = BUS_REQ.wdata & `EDGE_SEL_WMASK;
		end

		// Acknowledge clears the flag that was presented
		if (ack_irq) begin
			flags[st_r.vec_idx] = 1'b0;
		end
		if (ack_nmi) begin
			nmi = 1'b0;
		end

		// Hardware sets applied last so they win over any clear
		sets = '0;
		sets[`SRC_WDT] = SRC_EVENTS.wdt_ovf & WDT_INTERVAL_MODE;
		sets[`SRC_PIN_A] = edge_hit(esel[`ESEL_A_LSB +: 2], pin_a_rise, pin_a_fall);
		sets[`SRC_PIN_B] = edge_hit(esel[`ESEL_B_LSB +: 2], pin_b_rise, pin_b_fall);
		sets[`SRC_TI_RISE] = ti_rise;
		sets[`SRC_TI_FALL] = ti_fall;
		sets[`SRC_REMOTE] = SRC_EVENTS.remote_ovf;
		sets[`SRC_KEY] = SRC_EVENTS.key_scan;
		sets[`SRC_SERIAL] = SRC_EVENTS.serial_done;
		sets[`SRC_TM_A] = SRC_EVENTS.timer_a_match;
		sets[`SRC_TM_B] = SRC_EVENTS.timer_b_match;
		sets[`SRC_WATCH] = SRC_EVENTS.watch;
		sets[`SRC_WATCH_IV] = SRC_EVENTS.watch_interval;
		flags = flags | sets;
		if (SRC_EVENTS.wdt_ovf && !WDT_INTERVAL_MODE) begin
			nmi = 1'b1;
		end

		st_nxt.req_flags = flags;
		st_nxt.mask_flags = masks;
		st_nxt.edge_sel = esel;
		st_nxt.nmi_pending = nmi;

		// Read data, registered
		st_nxt.rdata = `RD_ZERO;
		if (BUS_REQ.rd) begin
			unique case (BUS_REQ.addr)
				`ADDR_REQ_LO: begin
					st_nxt.rdata = st_r.req_flags[7:0];
					if (!WDT_INTERVAL_MODE) begin
						st_nxt.rdata[`SRC_WDT] = 1'b0;
					end
				end
				`ADDR_REQ_HI: st_nxt.rdata = {4'h0, st_r.req_flags[11:8]};
				`ADDR_MASK_LO: st_nxt.rdata = st_r.mask_flags[7:0];
				`ADDR_MASK_HI: st_nxt.rdata = {4'hf, st_r.mask_flags[11:8]};
				`ADDR_EDGE_SEL: st_nxt.rdata = st_r.edge_sel;
				default: st_nxt.rdata = `RD_ZERO;
			endcase
		end

		// Maskable requests held back while the flag or mask registers are being touched
		flag_access = (wr_any | BUS_REQ.rd) &&
			(BUS_REQ.addr == `ADDR_REQ_LO || BUS_REQ.addr == `ADDR_REQ_HI ||
			BUS_REQ.addr == `ADDR_MASK_LO || BUS_REQ.addr == `ADDR_MASK_HI);

		// Non-maskable first; a maskable one needs the global enable
		st_nxt.nmi_out = st_r.nmi_pending & ~ack_nmi;
		st_nxt.irq_out = pick_valid & GLOBAL_IRQ_ENABLE & ~st_r.nmi_pending & ~flag_access &
			~ack_irq & ~ack_nmi;
		if (st_r.nmi_pending) begin
			st_nxt.vector = `NMI_VECTOR;
			st_nxt.vec_idx = st_r.vec_idx;
		end else begin
			st_nxt.vector = vector_of(pick_idx);
			st_nxt.vec_idx = pick_idx;
		end
		// Standby wake does not wait for the global enable
		st_nxt.standby = st_r.nmi_pending | (|eligible);
		st_nxt.ie_clear = ack_irq | ack_nmi;
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			st_r.req_flags <= 12'({`RST_REQ, `RST_REQ} >> 4);
			st_r.mask_flags <= 12'({`RST_MASK, `RST_MASK} >> 4);
			st_r.edge_sel <= `RST_EDGE_SEL;
			st_r.nmi_pending <= 1'b0;
			st_r.rdata <= `RD_ZERO;
			st_r.nmi_out <= 1'b0;
			st_r.irq_out <= 1'b0;
			st_r.vector <= `NMI_VECTOR;
			st_r.vec_idx <= 4'h0;
			st_r.standby <= 1'b0;
			st_r.ie_clear <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RDATA = st_r.rdata;
	assign NMI_REQ = st_r.nmi_out;
	assign IRQ_REQ = st_r.irq_out;
	assign VECTOR = st_r.vector;
	assign STANDBY_RELEASE = st_r.standby;
	assign IE_CLEAR = st_r.ie_clear;
endmodule // interrupt_request_control

// >>> sim/irq_ctl_properties.sv
// Concurrent checks on the interrupt request control ports
`timescale 1ns/1ps
module irq_ctl_properties (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire irq_pkg::bus_req_t BUS_REQ,
	input wire logic [7:0] RDATA,
	input wire irq_pkg::src_evt_t SRC_EVENTS,
	input wire logic PIN_A,
	input wire logic PIN_B,
	input wire logic TIMER_PIN,
	input wire logic WDT_INTERVAL_MODE,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic ACK,
	input wire logic NMI_REQ,
	input wire logic IRQ_REQ,
	input wire logic [15:0] VECTOR,
	input wire logic STANDBY_RELEASE,
	input wire logic IE_CLEAR
);
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);
	// Flag and mask registers only; the edge select byte does not hold requests back
	wire logic flag_acc = (BUS_REQ.rd | BUS_REQ.wr | BUS_REQ.bit_wr) & (BUS_REQ.addr[15:3] == 13'h1ffc)
		& ~BUS_REQ.addr[1];
	sequence s_taken;
		ACK && (IRQ_REQ || NMI_REQ);
	endsequence
	sequence s_retire;
		IE_CLEAR && !IRQ_REQ && !NMI_REQ ##1 !IE_CLEAR;
	endsequence
	AST_ACK_RETIRE: assert property (s_taken |=> s_retire)
		else $error("request not retired after ack");
	AST_NMI_FIRST: assert property (NMI_REQ |-> !IRQ_REQ && VECTOR == 16'h0004)
		else $error("non-maskable request not first");
	AST_NMI_HOLD: assert property (NMI_REQ && !ACK |=> NMI_REQ)
		else $error("non-maskable request dropped");
	AST_STANDBY: assert property ((NMI_REQ || IRQ_REQ) |-> STANDBY_RELEASE)
		else $error("no standby release");
	AST_VEC_MAP: assert property (IRQ_REQ |-> VECTOR inside {[16'h0004:16'h001a]} && !VECTOR[0])
		else $error("vector outside table");
	AST_ENABLE_GATE: assert property (!GLOBAL_IRQ_ENABLE |=> !IRQ_REQ)
		else $error("request while disabled");
	AST_ACCESS_HOLD: assert property (flag_acc |=> !IRQ_REQ)
		else $error("request during flag access");
	AST_IE_PULSE: assert property (IE_CLEAR |-> $past(ACK) ##1 !IE_CLEAR)
		else $error("enable clear without ack");
	AST_HI_MASK_READ: assert property (BUS_REQ.rd && BUS_REQ.addr == 16'hffe5 |=> RDATA[7:4] == 4'hf)
		else $error("upper mask bits not one");
endmodule // irq_ctl_properties

// >>> sim/core_model.sv
// Processor core stand-in: acknowledges requests and keeps the global enable
`timescale 1ns/1ps
module core_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic req,
	input wire logic ie_clear,
	input wire logic ei,
	input wire logic [3:0] wait_cyc,
	output logic ack,
	output logic ie
);
	logic [3:0] cnt;
	// Falling edge keeps ack and enable stable across the sampling edge
	always @(negedge clk or negedge nrst) begin
		if (!nrst) begin
			ack <= 1'b0;
			ie <= 1'b0;
			cnt <= 4'h0;
		end else begin
			ie <= ie_clear ? 1'b0 : ei;
			cnt <= (req && !ack && cnt != wait_cyc) ? cnt + 4'h1 : 4'h0;
			ack <= req && !ack && cnt == wait_cyc;
		end
	end
endmodule // core_model

// >>> sim/tb_interrupt_request_control.sv
// Self-checking bench for the interrupt request control
`timescale 1ns/1ps
module tb_interrupt_request_control;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	irq_pkg::bus_req_t br = '0;
	irq_pkg::src_evt_t ev = '0;
	logic pa = 1'b0;
	logic pb = 1'b1;
	logic tp = 1'b0;
	logic wim = 1'b1;
	logic ei = 1'b0;
	logic [3:0] wc = 4'h0;
	logic [7:0] rdata;
	logic [15:0] vec;
	logic nmi, irq, sb, iec, ack, ie;
	int error_cnt = 0;
	int cmp_count = 0;
	always #4 clk_sys = ~clk_sys;
	interrupt_request_control DUT (.CLK_SYS(clk_sys), .NRST(nrst), .BUS_REQ(br), .RDATA(rdata), .SRC_EVENTS(ev),
		.PIN_A(pa), .PIN_B(pb), .TIMER_PIN(tp), .WDT_INTERVAL_MODE(wim), .GLOBAL_IRQ_ENABLE(ie), .ACK(ack),
		.NMI_REQ(nmi), .IRQ_REQ(irq), .VECTOR(vec), .STANDBY_RELEASE(sb), .IE_CLEAR(iec));
	core_model u_core (.clk(clk_sys), .nrst(nrst), .req(nmi | irq), .ie_clear(iec), .ei(ei), .wait_cyc(wc),
		.ack(ack), .ie(ie));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cyc(1);
		br.addr = a;
		br.wdata = d;
		br.wr = 1'b1;
		cyc(1);
		br.wr = 1'b0;
	endtask
	task automatic wb(input logic [15:0] a, input logic [2:0] p, input logic v);
		cyc(1);
		br.addr = a;
		br.bit_pos = p;
		br.bit_val = v;
		br.bit_wr = 1'b1;
		cyc(1);
		br.bit_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		cyc(1);
		br.addr = a;
		br.rd = 1'b1;
		cyc(1);
		br.rd = 1'b0;
		chk({8'h00, rdata}, {8'h00, exp});
	endtask
	// Bounded waits: a lost request shows as an IE_CLEAR mismatch, not a hang
	task automatic serve(input logic [15:0] v);
		int n = 0;
		cyc(1);
		while ((irq | nmi) !== 1'b1 && n++ < 40)
			cyc(1);
		chk(vec, v);
		chk({15'h0000, sb}, 16'h0001);
		while (iec !== 1'b1 && n++ < 80)
			cyc(1);
		chk({15'h0000, iec}, 16'h0001);
	endtask
	task automatic t_reset;
		rd(16'hffe0, 8'h00);
		rd(16'hffe1, 8'h00);
		rd(16'hffe4, 8'hff);
		rd(16'hffe5, 8'hff);
		rd(16'hffec, 8'h00);
		rd(16'hffe2, 8'h00);
		chk(vec, 16'h0004);
	endtask
	task automatic t_prio;
		wr(16'hffec, 8'h34);
		wr(16'hffe4, 8'h00);
		wr(16'hffe5, 8'h00);
		rd(16'hffe5, 8'hf0);
		ei = 1'b1;
		cyc(1);
		ev = '1;
		pa = 1'b1;
		pb = 1'b0;
		tp = 1'b1;
		cyc(1);
		ev = '0;
		for (int i = 0; i < 12; i++)
			if (i != 4)
				serve(16'h0004 + 16'(2 * i));
		tp = 1'b0;
		serve(16'h000c);
	endtask
	task automatic t_nmi;
		wr(16'hffe4, 8'hff);
		ei = 1'b0;
		wim = 1'b0;
		cyc(1);
		ev.wdt_ovf = 1'b1;
		cyc(1);
		ev.wdt_ovf = 1'b0;
		serve(16'h0004);
		rd(16'hffe0, 8'h00);
	endtask
	task automatic t_soft;
		wb(16'hffe1, 3'h1, 1'b1);
		rd(16'hffe1, 8'h02);
		wb(16'hffe5, 3'h1, 1'b0);
		cyc(2);
		chk({14'h0000, irq, sb}, 16'h0001);
		ei = 1'b1;
		serve(16'h0016);
		rd(16'hffe1, 8'h00);
		wb(16'hffe5, 3'h1, 1'b1);
		wb(16'hffe1, 3'h2, 1'b1);
		wr(16'hffe1, 8'h00);
		rd(16'hffe1, 8'h00);
		ei = 1'b0;
	endtask
	task automatic t_race;
		cyc(1);
		br.addr = 16'hffe1;
		br.wdata = 8'h00;
		br.wr = 1'b1;
		ev.timer_a_match = 1'b1;
		cyc(1);
		br.wr = 1'b0;
		ev.timer_a_match = 1'b0;
		rd(16'hffe1, 8'h01);
	endtask
	task automatic complete_run;
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		complete_run();
	end
	initial begin
		cyc(2);
		nrst = 1'b1;
		t_reset();
		wc = 4'h3;
		t_prio();
		wc = 4'h0;
		t_nmi();
		t_soft();
		t_race();
		complete_run();
	end
endmodule // tb_interrupt_request_control
bind interrupt_request_control irq_ctl_properties u_props (.CLK_SYS(CLK_SYS), .NRST(NRST), .BUS_REQ(BUS_REQ),
	.RDATA(RDATA), .SRC_EVENTS(SRC_EVENTS), .PIN_A(PIN_A), .PIN_B(PIN_B), .TIMER_PIN(TIMER_PIN),
	.WDT_INTERVAL_MODE(WDT_INTERVAL_MODE), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .ACK(ACK), .NMI_REQ(NMI_REQ),
	.IRQ_REQ(IRQ_REQ), .VECTOR(VECTOR), .STANDBY_RELEASE(STANDBY_RELEASE), .IE_CLEAR(IE_CLEAR));
